/* logic/isra_pkg.sv */
package isra_pkg;
    // ==========================================================
    // bit counts and codes
    localparam int          BYTE_BITS     = 8;
    localparam logic [3:0]  ACK_EDGE      = 4'h9;    // ninth scl rising edge
    localparam logic [6:0]  ADDR_RESET    = 7'h00;
    localparam logic [7:0]  BUF_RESET     = 8'h00;
    localparam logic [4:0]  TEN_BIT_HIGH  = 5'h1e;   // 11110 prefix
    // master scl half period in system clocks (bench link 140 ns)
    localparam int          HALF_PERIOD_NS = 60;
    localparam int          CLK_NS         = 10;
    localparam int          HALF_CYCLES    = HALF_PERIOD_NS / CLK_NS;
    localparam logic [7:0]  HALF_CNT       = 8'(HALF_CYCLES);
endpackage

/* logic/isra_bus_if.sv */
`timescale 1ns/10ps
// ==========================================================
// open-drain i2c wires; each end drives low only
interface isra_bus_if;
    logic sclDevOe;
    logic sdaDevOe;
    logic sclHostOe;
    logic sdaHostOe;
    logic scl;
    logic sda;

    assign scl = ~(sclDevOe | sclHostOe);
    assign sda = ~(sdaDevOe | sdaHostOe);

    modport device (input scl, input sda, output sclDevOe, output sdaDevOe);
    modport host   (input scl, input sda, output sclHostOe,
                    output sdaHostOe);
endinterface

/* logic/isra_slave.sv */
`timescale 1ns/10ps
module isra_slave
    import isra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    isra_bus_if.device      bus,
    input  wire logic [6:0] slaveAddress,
    input  wire logic       tenBitMode,
    input  wire logic [1:0] tenBitHigh,
    input  wire logic       addressHoldEnable,
    input  wire logic       startIrqEnable,
    input  wire logic       stopIrqEnable,
    input  wire logic       startStopNative,
    input  wire logic       ackDataSelect,
    input  wire logic       clockReleaseSet,
    input  wire logic       irqFlagClear,
    input  wire logic       bufferRead,
    input  wire logic       bufferWrite,
    input  wire logic [7:0] bufferWriteData,
    output logic [7:0]      serialDataBuffer,
    output logic            bufferFullFlag,
    output logic            serialPortIrqFlag,
    output logic            clockReleaseBit,
    output logic            ackTimeStatus,
    output logic            readWriteStatus,
    output logic            dataAddressStatus,
    output logic            ackStatusBit,
    output logic            startDetected,
    output logic            stopDetected,
    output logic            priorMatch
);
    import isra_pkg::*;

    typedef enum {ISRA_IDLE, ISRA_ADDR, ISRA_AACK, ISRA_TX, ISRA_TACK,
                  ISRA_RX, ISRA_RACK} isra_state_t;

    // ==========================================================
    // pin synchronisers
    logic [1:0] sclSync, sdaSync;
    logic       sclPrev, sdaPrev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[0], bus.scl};
            sdaSync <= {sdaSync[0], bus.sda};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end

    logic sclS, sdaS, sclRise, sclFall, startEv, stopEv;
    assign sclS    = sclSync[1];
    assign sdaS    = sdaSync[1];
    assign sclRise = sclS & ~sclPrev;
    assign sclFall = ~sclS & sclPrev;

    // ==========================================================
    // protocol state
    isra_state_t state, next_state;
    logic [3:0]  bitCnt, next_bitCnt;
    logic [7:0]  shiftReg, next_shiftReg;
    logic        sawLow, next_sawLow;
    logic        sdaOe, next_sdaOe;
    logic        highMatched, next_highMatched;
    logic        isHighByte, next_isHighByte;
    logic [7:0]  next_buffer;
    logic        next_bf, next_irq, next_ckp, next_ack_time_status, next_rw, next_da;
    logic        next_ack_status_bit, next_start, next_stop, next_prior;

    assign startEv = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopEv  = sclS & sclPrev & ~sdaPrev & sdaS & sawLow;

    // address compare for 7-bit or either 10-bit byte
    function automatic logic isMatch(input logic [7:0] b, input logic hi,
                                     input logic ten);
        if (!ten)
            isMatch = (b[7:1] == slaveAddress);
        else if (hi)
            isMatch = (b[7:3] == TEN_BIT_HIGH) && (b[2:1] == tenBitHigh);
        else
            isMatch = (b == {slaveAddress, 1'b0});
    endfunction

    // next-value logic
    always_comb begin
        next_state       = state;
        next_bitCnt      = bitCnt;
        next_shiftReg    = shiftReg;
        next_sawLow      = sawLow;
        next_sdaOe       = sdaOe;
        next_highMatched = highMatched;
        next_isHighByte  = isHighByte;
        next_buffer      = serialDataBuffer;
        next_bf          = bufferFullFlag;
        next_irq         = serialPortIrqFlag;
        next_ckp         = clockReleaseBit;
        next_ack_time_status      = ackTimeStatus;
        next_rw          = readWriteStatus;
        next_da          = dataAddressStatus;
        next_ack_status_bit     = ackStatusBit;
        next_start       = startDetected;
        next_stop        = stopDetected;
        next_prior       = priorMatch;

        // software side effects; hardware set later wins
        if (irqFlagClear)
            next_irq = 1'b0;
        if (clockReleaseSet)
            next_ckp = 1'b1;
        if (bufferRead)
            next_bf = 1'b0;
        if (bufferWrite && state != ISRA_AACK && state != ISRA_TACK) begin
            next_buffer = bufferWriteData;
            next_bf     = 1'b1;
        end
        if (!sclS)
            next_sawLow = 1'b1;

        if (startEv) begin
            // start and restart reset the transfer logic; priorMatch and readWriteStatus are kept
            next_state   = ISRA_ADDR;
            next_bitCnt  = 4'h0;
            next_sdaOe   = 1'b0;
            next_ckp     = 1'b1;
            next_ack_time_status  = 1'b0;
            next_da      = 1'b0;
            next_start   = 1'b1;
            next_stop    = 1'b0;
            next_sawLow  = 1'b0;
            next_isHighByte = tenBitMode;
            next_highMatched = 1'b0;
            if (startIrqEnable && !startStopNative)
                next_irq = 1'b1;
        end else if (stopEv) begin
            next_state  = ISRA_IDLE;
            next_sdaOe  = 1'b0;
            next_ckp    = 1'b1;
            next_stop   = 1'b1;
            next_start  = 1'b0;
            next_prior  = 1'b0;
            next_sawLow = 1'b0;
            if (stopIrqEnable && !startStopNative)
                next_irq = 1'b1;
        end else begin
            unique case (state)
                ISRA_IDLE: ;
                ISRA_ADDR, ISRA_RX: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaS};
                        next_bitCnt   = bitCnt + 4'h1;
                    end
                    if (sclFall && bitCnt == 4'(BYTE_BITS)) begin
                        next_bitCnt = 4'h0;
                        if (state == ISRA_RX) begin
                            next_state = ISRA_RACK;
                            next_sdaOe = 1'b1;
                        end else if (isMatch(shiftReg, isHighByte,
                                             tenBitMode)) begin
                            next_buffer = shiftReg;
                            next_bf     = 1'b1;
                            next_rw     = shiftReg[0];
                            next_da     = 1'b0;
                            next_ack_time_status = 1'b1;
                            next_state  = ISRA_AACK;
                            if (isHighByte) begin
                                next_highMatched = 1'b1;
                                if (!shiftReg[0])
                                    next_prior = 1'b0;
                            end
                            if (addressHoldEnable) begin
                                next_ckp = 1'b0;
                                next_irq = 1'b1;
                            end else
                                next_sdaOe = 1'b1;
                        end else begin
                            if (isHighByte)
                                next_prior = 1'b0;
                            next_state = ISRA_IDLE;
                        end
                    end
                end
                ISRA_AACK: begin
                    // settle the chosen ack while scl is still low, so sda
                    // never moves after the stretch is released
                    if (!sclS)
                        next_sdaOe = ~ackDataSelect;
                    if (sclFall && bitCnt == 4'h1) begin
                        next_sdaOe  = 1'b0;
                        next_ack_time_status = 1'b0;
                        next_bitCnt = 4'h0;
                        if (ackDataSelect)
                            next_state = ISRA_IDLE;
                        else if (isHighByte && rw_hi_read()) begin
                            // 10-bit read after restart
                            next_state = ISRA_TX;
                            next_ckp   = 1'b0;
                            next_irq   = 1'b1;
                        end else if (isHighByte) begin
                            next_isHighByte = 1'b0;
                            next_state = ISRA_ADDR;
                        end else if (readWriteStatus && !tenBitMode) begin
                            next_state = ISRA_TX;
                            next_ckp   = 1'b0;
                            next_irq   = 1'b1;
                        end else begin
                            if (tenBitMode)
                                next_prior = 1'b1;
                            next_state = ISRA_RX;
                            next_da    = 1'b1;
                        end
                    end else if (sclRise)
                        next_bitCnt = 4'h1;
                end
                ISRA_TX: begin
                    // each bit is set while scl is low, stretched or not
                    next_da = 1'b1;
                    if (!sclS && bitCnt < 4'(BYTE_BITS))
                        next_sdaOe = ~serialDataBuffer[3'(7 - bitCnt)];
                    if (sclRise)
                        next_bitCnt = bitCnt + 4'h1;
                    if (sclFall && bitCnt == 4'(BYTE_BITS)) begin
                        next_sdaOe = 1'b0;
                        next_bf    = 1'b0;
                        next_state = ISRA_TACK;
                    end
                end
                ISRA_TACK: begin
                    if (sclRise) begin
                        next_ack_status_bit = sdaS;
                        next_ack_time_status  = 1'b1;
                    end
                    if (sclFall && ackTimeStatus) begin
                        next_ack_time_status = 1'b0;
                        next_bitCnt = 4'h0;
                        if (ackStatusBit)
                            next_state = ISRA_IDLE;
                        else begin
                            next_state = ISRA_TX;
                            next_ckp   = 1'b0;
                            next_irq   = 1'b1;
                        end
                    end
                end
                ISRA_RACK: begin
                    if (sclFall && bitCnt == 4'h1) begin
                        next_sdaOe  = 1'b0;
                        next_buffer = shiftReg;
                        next_bf     = 1'b1;
                        next_irq    = 1'b1;
                        next_bitCnt = 4'h0;
                        next_state  = ISRA_RX;
                    end else if (sclRise)
                        next_bitCnt = 4'h1;
                end
            endcase
        end
    end

    // read direction latched with the high byte of a 10-bit restart
    function automatic logic rw_hi_read();
        rw_hi_read = readWriteStatus && priorMatch;
    endfunction

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state             <= ISRA_IDLE;
            bitCnt            <= 4'h0;
            shiftReg          <= BUF_RESET;
            sawLow            <= 1'b0;
            sdaOe             <= 1'b0;
            highMatched       <= 1'b0;
            isHighByte        <= 1'b0;
            serialDataBuffer  <= BUF_RESET;
            bufferFullFlag    <= 1'b0;
            serialPortIrqFlag <= 1'b0;
            clockReleaseBit   <= 1'b1;
            ackTimeStatus     <= 1'b0;
            readWriteStatus   <= 1'b0;
            dataAddressStatus <= 1'b0;
            ackStatusBit      <= 1'b0;
            startDetected     <= 1'b0;
            stopDetected      <= 1'b0;
            priorMatch        <= 1'b0;
        end else begin
            state             <= next_state;
            bitCnt            <= next_bitCnt;
            shiftReg          <= next_shiftReg;
            sawLow            <= next_sawLow;
            sdaOe             <= next_sdaOe;
            highMatched       <= next_highMatched;
            isHighByte        <= next_isHighByte;
            serialDataBuffer  <= next_buffer;
            bufferFullFlag    <= next_bf;
            serialPortIrqFlag <= next_irq;
            clockReleaseBit   <= next_ckp;
            ackTimeStatus     <= next_ack_time_status;
            readWriteStatus   <= next_rw;
            dataAddressStatus <= next_da;
            ackStatusBit      <= next_ack_status_bit;
            startDetected     <= next_start;
            stopDetected      <= next_stop;
            priorMatch        <= next_prior;
        end
    end

    // open-drain drives
    assign bus.sclDevOe = ~clockReleaseBit;
    assign bus.sdaDevOe = sdaOe;
endmodule

/* logic/isra_master.sv */
`timescale 1ns/10ps
// ==========================================================
// simple master: start/restart, byte write, byte read, stop
module isra_master
    import isra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    isra_bus_if.host        bus,
    input  wire logic       cmdValid,
    input  wire logic [2:0] cmdOp,      // 0 start 1 write 2 read 3 stop
    input  wire logic [7:0] cmdData,
    input  wire logic       cmdNack,    // ack value sent after a read
    output logic            cmdReady,
    output logic [7:0]      rdData,
    output logic            rdAck
);
    import isra_pkg::*;

    typedef enum {ISRA_M_IDLE, ISRA_M_WORK} isra_mstate_t;

    // ==========================================================
    // scl sampled through two flops for stretch detection
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
        end else begin
            sclSync <= {sclSync[0], bus.scl};
            sdaSync <= {sdaSync[0], bus.sda};
        end
    end

    isra_mstate_t mState, next_mState;
    logic [2:0]   op, next_op;
    logic [5:0]   phase, next_phase;   // half-period steps
    logic [7:0]   tick, next_tick;
    logic [8:0]   sh, next_sh;
    logic         sclOe, next_sclOe, sdaOe, next_sdaOe;
    logic [7:0]   next_rdData;
    logic         next_rdAck, nackReg, next_nackReg;

    // step logic: each phase lasts HALF_CNT + 1 clocks, stalled by stretch
    always_comb begin
        next_mState  = mState;
        next_op      = op;
        next_phase   = phase;
        next_tick    = tick;
        next_sh      = sh;
        next_sclOe   = sclOe;
        next_sdaOe   = sdaOe;
        next_rdData  = rdData;
        next_rdAck   = rdAck;
        next_nackReg = nackReg;
        unique case (mState)
            ISRA_M_IDLE: begin
                if (cmdValid) begin
                    next_mState  = ISRA_M_WORK;
                    next_op      = cmdOp;
                    next_phase   = 6'h0;
                    next_tick    = 8'h0;
                    next_sh      = {cmdData, 1'b1};
                    next_nackReg = cmdNack;
                end
            end
            ISRA_M_WORK: begin
                if (!sclOe && !sclSync[1])
                    next_tick = tick;                  // slave stretching
                else if (tick != HALF_CNT)
                    next_tick = tick + 8'h1;
                else begin
                    next_tick  = 8'h0;
                    next_phase = phase + 6'h1;
                    unique case (op)
                        3'h0: begin                    // start / restart
                            unique case (phase)
                                6'h0: begin next_sdaOe = 1'b0; end
                                6'h1: begin next_sclOe = 1'b0; end
                                6'h2: begin next_sdaOe = 1'b1; end
                                default: begin
                                    next_sclOe  = 1'b1;
                                    next_mState = ISRA_M_IDLE;
                                end
                            endcase
                        end
                        3'h3: begin                    // stop
                            unique case (phase)
                                6'h0: begin next_sdaOe = 1'b1; end
                                6'h1: begin next_sclOe = 1'b0; end
                                default: begin
                                    next_sdaOe  = 1'b0;
                                    next_mState = ISRA_M_IDLE;
                                end
                            endcase
                        end
                        default: begin                 // 9 bits write/read
                            if (!phase[0]) begin
                                // scl low half: set data
                                if (op == 3'h1)
                                    next_sdaOe = (phase < 6'h10) ?
                                                 ~sh[8] : 1'b0;
                                else
                                    next_sdaOe = (phase < 6'h10) ? 1'b0 :
                                                 ~nackReg;
                                next_sclOe = 1'b0;
                            end else begin
                                // scl high half: sample
                                next_sclOe = 1'b0;
                                if (phase < 6'h10) begin
                                    next_sh = {sh[7:0], sdaSync[1]};
                                end else begin
                                    next_rdAck  = sdaSync[1];
                                    next_rdData = sh[7:0];
                                    next_mState = ISRA_M_IDLE;
                                end
                            end
                            if (phase[0])
                                next_sclOe = 1'b1;     // hold low next
                            else
                                next_sclOe = 1'b0;     // release high
                            if (phase == 6'h11)
                                next_sdaOe = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mState  <= ISRA_M_IDLE;
            op      <= 3'h0;
            phase   <= 6'h0;
            tick    <= 8'h0;
            sh      <= 9'h000;
            sclOe   <= 1'b0;
            sdaOe   <= 1'b0;
            rdData  <= 8'h00;
            rdAck   <= 1'b1;
            nackReg <= 1'b1;
        end else begin
            mState  <= next_mState;
            op      <= next_op;
            phase   <= next_phase;
            tick    <= next_tick;
            sh      <= next_sh;
            sclOe   <= next_sclOe;
            sdaOe   <= next_sdaOe;
            rdData  <= next_rdData;
            rdAck   <= next_rdAck;
            nackReg <= next_nackReg;
        end
    end

    assign cmdReady      = (mState == ISRA_M_IDLE);
    assign bus.sclHostOe = sclOe;
    assign bus.sdaHostOe = sdaOe;
endmodule

/* verif/isra_asserts.sv */
`timescale 1ns/10ps
// ==========================================================
// wire-level checks on the open-drain bus
module isra_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclDevOe,
    input wire logic sdaDevOe,
    input wire logic sclHostOe,
    input wire logic sdaHostOe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus conditions seen on the wires
    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    property p_start_free; s_start |-> ##4 !sdaDevOe; endproperty
    property p_stop_free; s_stop |-> ##4 !sclDevOe && !sdaDevOe; endproperty
    property p_sda_low; $changed(sdaDevOe) |-> !$past(scl); endproperty
    property p_hold_low; $rose(sclDevOe) |-> $past(sclHostOe); endproperty
    property p_start_scl; s_start |-> ##4 !sclDevOe; endproperty
    property p_ack_rise; $rose(sdaDevOe) |-> !scl; endproperty
    a_start_free: assert property (p_start_free)
        else $error("slave drives sda after start");
    a_stop_free: assert property (p_stop_free)
        else $error("slave holds bus after stop");
    a_sda_low: assert property (p_sda_low)
        else $error("slave moved sda while scl high");
    a_hold_low: assert property (p_hold_low)
        else $error("slave stretch began with scl high");
    a_start_scl: assert property (p_start_scl)
        else $error("slave holds scl after start");
    a_ack_rise: assert property (p_ack_rise)
        else $error("slave pulled sda low while scl high");
    c_start: cover property (s_start);
endmodule

/* verif/i2c_slave_restart_addr_hold_test.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errors++; \
    $display("wrong value at %0t: %h expected %h", $time, a, e); end end
module i2c_slave_restart_addr_hold_test;
    import isra_pkg::*;
    logic clk = 0, rst_n = 0, cmdValid = 0, cmdNack = 0, cmdReady, rdAck;
    logic [2:0] cmdOp = 0;
    logic [7:0] cmdData = 0, rdData, buf_q, wrData = 0;
    logic [3:0] sw = 0;
    logic ackSel = 0, full, irq, ckRel, ackT, rw, da, ackS, sDet, pDet, pm;
    logic address_hold_enable = 1, pIrqEn = 0;
    int errors = 0, numChecks = 0;
    isra_bus_if bus ();
    // ==========================================================
    // both ends joined on one bus
    isra_slave i_isra_slave (.clk(clk), .rst_n(rst_n), .bus(bus),
        .slaveAddress(7'h5a), .tenBitMode(1'b0), .tenBitHigh(2'h0),
        .addressHoldEnable(address_hold_enable), .startIrqEnable(1'b1),
        .stopIrqEnable(pIrqEn), .startStopNative(1'b0), .ackDataSelect(ackSel),
        .clockReleaseSet(sw[0]), .irqFlagClear(sw[1]), .bufferRead(sw[2]),
        .bufferWrite(sw[3]), .bufferWriteData(wrData),
        .serialDataBuffer(buf_q), .bufferFullFlag(full),
        .serialPortIrqFlag(irq), .clockReleaseBit(ckRel),
        .ackTimeStatus(ackT), .readWriteStatus(rw), .dataAddressStatus(da),
        .ackStatusBit(ackS), .startDetected(sDet), .stopDetected(pDet),
        .priorMatch(pm));
    isra_master i_isra_master (.clk(clk), .rst_n(rst_n), .bus(bus),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData),
        .cmdNack(cmdNack), .cmdReady(cmdReady), .rdData(rdData),
        .rdAck(rdAck));
    isra_asserts i_isra_asserts (.clk(clk), .rst_n(rst_n),
        .sclDevOe(bus.sclDevOe), .sdaDevOe(bus.sdaDevOe),
        .sclHostOe(bus.sclHostOe), .sdaHostOe(bus.sdaHostOe),
        .scl(bus.scl), .sda(bus.sda));
    always #5 clk = ~clk;
    task finishTest;
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one master command, held for one clock
    task issue(input logic [2:0] op, input logic [7:0] d, input logic nk);
        @(posedge clk) #1 {cmdValid, cmdOp, cmdData, cmdNack} = {1'b1, op, d, nk};
        @(posedge clk) #1 cmdValid = 0;
    endtask
    // bounded wait for master idle or slave irq
    task waitFor(input bit onIrq);
        for (int i = 0; i <= 5000; i++) begin
            @(posedge clk) #1;
            if (onIrq ? irq === 1'b1 : cmdReady === 1'b1) return;
        end
        errors++;
        finishTest();
    endtask
    task pulse(input logic [3:0] p);
        @(posedge clk) #1 sw = p;
        @(posedge clk) #1 sw = 0;
    endtask
    // address-hold read of one byte ending with nack and stop
    task testHoldRead;
        issue(3'h0, 8'h00, 1'b0); waitFor(0);
        `CHK({sDet, irq}, 2'b11)
        pulse(4'h2); issue(3'h1, 8'hb5, 1'b0); waitFor(1);
        `CHK({ckRel, ackT, rw, da, full}, 5'b01101)
        `CHK(buf_q, 8'hb5)
        repeat (20) @(posedge clk);
        `CHK(irq, 1'b1)
        pulse(4'h2); pulse(4'h4);
        `CHK(full, 1'b0)
        wrData = 8'h33; pulse(4'h8);
        `CHK(full, 1'b0)
        pulse(4'h1);
        `CHK(ckRel, 1'b1)
        waitFor(0);
        `CHK(rdAck, 1'b0)
        waitFor(1);
        `CHK(ckRel, 1'b0)
        pulse(4'h2); wrData = 8'hc3; pulse(4'h8);
        `CHK(full, 1'b1)
        pulse(4'h1);
        issue(3'h2, 8'h00, 1'b1);
        waitFor(0);
        `CHK({rdData, ackS}, 9'h187)
        issue(3'h3, 8'h00, 1'b0); waitFor(0); repeat (8) @(posedge clk);
        `CHK({pDet, bus.scl, bus.sda}, 3'b111)
        $display("test hold read done");
    endtask
    // restart then a foreign address gets no ack
    task testRestartMiss;
        issue(3'h0, 8'h00, 1'b0); waitFor(0); ackSel = 1;
        pulse(4'h2); issue(3'h0, 8'h00, 1'b0); waitFor(0);
        `CHK({sDet, irq}, 2'b11)
        issue(3'h1, 8'h24, 1'b0); waitFor(0);
        `CHK({rdAck, ckRel}, 2'b11)
        pulse(4'h2); pIrqEn = 1;
        issue(3'h3, 8'h00, 1'b0); waitFor(0); repeat (8) @(posedge clk);
        `CHK({irq, pDet}, 2'b11)
        $display("test restart miss done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        testHoldRead();
        testRestartMiss();
        finishTest();
    end
endmodule
